// file: rtl/adc_result_accumulator_formatter.v
// converter result path: start control, accumulation, formatting, apb registers
//
// Contract
// - conversion result lands in high/low bytes
// - justify field: 000 right, 100 left
// - single result is unsigned 10-bit code
// - unused result bits read zero
// - full scale 0x03FF right, 0xFFC0 left
// - series sum published after final conversion
// - series of 4 to 64 samples, unsigned
// - repeat count from accumulator config register
// - 16-bit accumulator sums without processor help
// - sum may shift right one to three
// - burst powers converter up, then down
// - 10-bit 300 ksps, 12-bit 75 ksps
// - done flag only after full series
// - burst: one start runs whole series
// - busy falls at completion, setting done
`include "adc_result_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module adc_result_accumulator_formatter
(
    input  wire        clk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        extStart,
    input  wire        sampleValid,
    input  wire [11:0] sampleCode,
    output reg         convStart_q,
    output reg         powerUp_q,
    output reg         res12Mode_q,
    output reg         irq_q
);
    // sequencer states
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_WAKE = 3'h1;
    localparam [2:0] S_GAP  = 3'h2;
    localparam [2:0] S_CONV = 3'h3;
    localparam [2:0] S_PUB  = 3'h4;

    // counts loaded into the down counters; worked out at full width, cut to the counter width
    localparam integer RATE10_FULL = `RATE10_CYCLES - 1;
    localparam integer RATE12_FULL = `RATE12_CYCLES - 1;
    localparam integer WAKE_FULL   = `PWRUP_CYCLES - 1;
    localparam [10:0]  RATE10_LOAD = RATE10_FULL[10:0];
    localparam [10:0]  RATE12_LOAD = RATE12_FULL[10:0];
    localparam [10:0]  WAKE_LOAD   = WAKE_FULL[10:0];

    reg  [3:0]  ctrl_q;          // burst, start(unused), res12, enable
    reg  [5:0]  accCfg_q;        // repeat_count_select and justify_shift_select
    reg  [15:0] result_q;        // published result pair
    reg         doneFlag_q;      // conversion_done_flag
    reg         inProgress_q;    // conversion_in_progress
    reg  [1:0]  intStatus_q;     // sticky events
    reg  [1:0]  intMask_q;       // interrupt enables
    reg  [2:0]  state_q;         // sequencer state
    reg  [2:0]  state_d;
    reg  [6:0]  sampleCnt_q;     // samples taken in this series
    reg  [10:0] gapCnt_q;        // cycles before the next start is allowed
    reg  [10:0] wakeCnt_q;       // power-up wait
    reg         burstRun_q;      // series was launched in burst mode
    reg  [6:0]  repeatCount;     // decoded repeat count
    reg  [31:0] readData;        // read mux
    reg         readErr;         // unmapped address

    wire        apbAccess;       // access phase of a transfer
    wire        apbDone;         // edge where the transfer completes
    wire        wrDone;          // write takes effect here
    wire        regStart;        // software start write
    wire        startReq;        // any convert-start event
    wire        startTaken;      // start accepted by the sequencer
    wire        startDropped;    // start arrived while busy
    wire        lastSample;      // this sample closes the series
    wire        firstSample;     // this sample opens the series
    wire        sampleIn;        // sample accepted in conversion state
    wire        publish;         // result update cycle
    wire [15:0] accSum;          // accumulator output
    wire [15:0] fmtResult;       // formatted result
    wire [11:0] codeIn;          // sample trimmed to resolution
    wire [2:0]  sjst;            // justify_shift_select
    wire [2:0]  rptSel;          // repeat_count_select
    wire        burstEn;         // burst mode enable
    wire        convEnable;      // converter kept powered while idle

    assign sjst       = accCfg_q[`ACC_SJST_MSB:`ACC_SJST_LSB];
    assign rptSel     = accCfg_q[`ACC_RPT_MSB:`ACC_RPT_LSB];
    assign burstEn    = ctrl_q[`CTRL_BURST_BIT];
    assign convEnable = ctrl_q[`CTRL_ENABLE_BIT];

    // apb handshake: pready is raised on the second access cycle
    assign apbAccess = psel & penable;
    assign apbDone   = apbAccess & pready;
    assign wrDone    = apbDone & pwrite;
    assign regStart  = wrDone & (paddr == `OFS_CTRL) & pwdata[`CTRL_START_BIT];

    // start events: register write or external pin pulse
    assign startReq     = regStart | extStart;
    assign startTaken   = startReq & (state_q == S_IDLE);
    assign startDropped = startReq & (state_q != S_IDLE);

    // 10-bit mode keeps only the low ten bits of the core code
    assign codeIn = res12Mode_q ? sampleCode : {2'b00, sampleCode[9:0]};

    assign sampleIn    = sampleValid & (state_q == S_CONV);
    assign firstSample = sampleIn & (sampleCnt_q == 7'h00);
    assign lastSample  = sampleIn & ((sampleCnt_q + 7'h01) == repeatCount);
    assign publish     = (state_q == S_PUB);

    // repeat count decode; unused codes behave as one sample
    always @*
    begin
        case (rptSel)
            3'h1:    repeatCount = 7'd4;
            3'h2:    repeatCount = 7'd8;
            3'h3:    repeatCount = 7'd16;
            3'h4:    repeatCount = 7'd32;
            3'h5:    repeatCount = 7'd64;
            default: repeatCount = 7'd1;
        endcase
    end

    sample_accumulator u_acc
    (
        .clk    (clk),
        .rst    (rst),
        .load   (firstSample),
        .add    (sampleIn),
        .sample (codeIn),
        .sum_q  (accSum)
    );

    // formatting is applied at publish time, so a format change made mid-series applies to that series
    result_formatter u_fmt
    (
        .sum   (accSum),
        .sjst  (sjst),
        .res12 (res12Mode_q),
        .fmt   (fmtResult)
    );

    // sequencer next state
    always @*
    begin
        state_d = state_q;
        case (state_q)
            S_IDLE:
            begin
                if (startTaken)
                begin
                    if (burstEn & ~powerUp_q)
                        state_d = S_WAKE;
                    else
                        state_d = S_GAP;
                end
            end
            S_WAKE:
            begin
                if (wakeCnt_q == 11'h000)
                    state_d = S_GAP;
            end
            S_GAP:
            begin
                // the rate counter enforces the per-mode sample spacing
                if (gapCnt_q == 11'h000)
                    state_d = S_CONV;
            end
            S_CONV:
            begin
                if (lastSample)
                    state_d = S_PUB;
                else if (sampleIn & burstRun_q)
                    state_d = S_GAP;
                else if (sampleIn)
                    state_d = S_IDLE;
            end
            S_PUB:
                state_d = S_IDLE;
            default:
                state_d = S_IDLE;
        endcase
    end

    // sequencer registers and converter control outputs
    always @(posedge clk)
    begin
        if (rst)
        begin
            state_q      <= S_IDLE;
            sampleCnt_q  <= 7'h00;
            gapCnt_q     <= 11'h000;
            wakeCnt_q    <= 11'h000;
            burstRun_q   <= 1'b0;
            convStart_q  <= 1'b0;
            powerUp_q    <= 1'b0;
            inProgress_q <= 1'b0;
            res12Mode_q  <= 1'b0;
        end
        else
        begin
            state_q     <= state_d;
            convStart_q <= 1'b0;
            // resolution only changes while idle, which outside burst includes between samples of a series
            if (state_q == S_IDLE)
                res12Mode_q <= ctrl_q[`CTRL_RES12_BIT];
            // rate spacing counts down continuously
            if (gapCnt_q != 11'h000)
                gapCnt_q <= gapCnt_q - 11'h001;
            if (wakeCnt_q != 11'h000)
                wakeCnt_q <= wakeCnt_q - 11'h001;
            // outside burst the converter power follows the enable bit
            if (~burstRun_q & (state_q == S_IDLE))
                powerUp_q <= convEnable;
            if (startTaken)
            begin
                burstRun_q   <= burstEn;
                inProgress_q <= 1'b1;
                if (burstEn & ~powerUp_q)
                begin
                    powerUp_q <= 1'b1;
                    wakeCnt_q <= WAKE_LOAD;
                end
            end
            // launch one conversion and restart the spacing counter
            if ((state_q == S_GAP) & (gapCnt_q == 11'h000))
            begin
                convStart_q  <= 1'b1;
                inProgress_q <= 1'b1;
                gapCnt_q     <= res12Mode_q ? RATE12_LOAD : RATE10_LOAD;
            end
            if (sampleIn)
            begin
                if (lastSample)
                    sampleCnt_q <= 7'h00;
                else
                    sampleCnt_q <= sampleCnt_q + 7'h01;
                // between single conversions busy drops; within a burst it holds
                if (~lastSample & ~burstRun_q)
                    inProgress_q <= 1'b0;
            end
            if (publish)
            begin
                inProgress_q <= 1'b0;
                burstRun_q   <= 1'b0;
                // burst returns the converter to shutdown unless kept enabled
                if (burstRun_q)
                    powerUp_q <= convEnable;
            end
        end
    end

    // result pair and completion flag
    always @(posedge clk)
    begin
        if (rst)
        begin
            result_q   <= 16'h0000;
            doneFlag_q <= 1'b0;
        end
        else
        begin
            if (publish)
                result_q <= fmtResult;
            // completion sets the flag; a clear in the same cycle loses
            if (publish)
                doneFlag_q <= 1'b1;
            else if (wrDone & (paddr == `OFS_STATUS) & pwdata[`ST_DONE_BIT])
                doneFlag_q <= 1'b0;
        end
    end

    // configuration registers written by software
    always @(posedge clk)
    begin
        if (rst)
        begin
            ctrl_q    <= `CTRL_RESET;
            accCfg_q  <= `ACC_CFG_RESET;
            intMask_q <= `INT_RESET;
        end
        else if (wrDone)
        begin
            case (paddr)
                `OFS_CTRL:
                    ctrl_q <= {pwdata[`CTRL_ENABLE_BIT], pwdata[`CTRL_RES12_BIT], 1'b0, pwdata[`CTRL_BURST_BIT]};
                `OFS_ACC_CFG:
                    accCfg_q <= pwdata[5:0];
                `OFS_INT_MASK:
                    intMask_q <= pwdata[1:0];
                default:
                    ctrl_q <= ctrl_q;
            endcase
        end
    end

    // sticky interrupt events and the level interrupt output
    always @(posedge clk)
    begin
        if (rst)
        begin
            intStatus_q <= `INT_RESET;
            irq_q       <= 1'b0;
        end
        else
        begin
            // write-one clears first, then new events override it
            if (wrDone & (paddr == `OFS_INT_STATUS))
                intStatus_q <= (intStatus_q & ~pwdata[1:0]) | {startDropped, publish};
            else
                intStatus_q <= intStatus_q | {startDropped, publish};
            irq_q <= |(intStatus_q & intMask_q);
        end
    end

    // read multiplexer; unmapped addresses answer with an error and zero data
    always @*
    begin
        readData = 32'h0000_0000;
        readErr  = 1'b0;
        case (paddr)
            `OFS_CTRL:        readData = {28'h0000000, ctrl_q};
            `OFS_ACC_CFG:     readData = {26'h0000000, accCfg_q};
            `OFS_STATUS:      readData = {28'h0000000, (state_q != S_IDLE), powerUp_q, doneFlag_q, inProgress_q};
            `OFS_RESULT:      readData = {16'h0000, result_q};
            `OFS_RESULT_HIGH: readData = {24'h000000, result_q[15:8]};
            `OFS_RESULT_LOW:  readData = {24'h000000, result_q[7:0]};
            `OFS_INT_STATUS:  readData = {30'h00000000, intStatus_q};
            `OFS_INT_MASK:    readData = {30'h00000000, intMask_q};
            default:          readErr = 1'b1;
        endcase
    end

    // apb answer: one wait state, read data captured with pready
    always @(posedge clk)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= apbAccess & ~pready;
            pslverr <= apbAccess & ~pready & readErr;
            if (apbAccess & ~pready & ~pwrite)
                prdata <= readData;
            else
                prdata <= 32'h0000_0000;
        end
    end
endmodule
`default_nettype wire

// file: rtl/adc_result_consts.vh
// constants for the converter result accumulator and formatter
`ifndef ADC_RESULT_CONSTS_VH
`define ADC_RESULT_CONSTS_VH

// register byte offsets
`define OFS_CTRL        8'h00
`define OFS_ACC_CFG     8'h04
`define OFS_STATUS      8'h08
`define OFS_RESULT      8'h0c
`define OFS_RESULT_HIGH 8'h10
`define OFS_RESULT_LOW  8'h14
`define OFS_INT_STATUS  8'h18
`define OFS_INT_MASK    8'h1c

// control register fields
`define CTRL_BURST_BIT   0
`define CTRL_START_BIT   1
`define CTRL_RES12_BIT   2
`define CTRL_ENABLE_BIT  3
`define CTRL_RESET       4'h0

// accumulator configuration fields
`define ACC_RPT_LSB      0
`define ACC_RPT_MSB      2
`define ACC_SJST_LSB     3
`define ACC_SJST_MSB     5
`define ACC_CFG_RESET    6'h00

// status register fields
`define ST_BUSY_BIT      0
`define ST_DONE_BIT      1
`define ST_POWER_BIT     2
`define ST_ACTIVE_BIT    3

// interrupt status / mask fields
`define INT_DONE_BIT     0
`define INT_DROP_BIT     1
`define INT_RESET        2'h0

// justify/shift encodings
`define SJST_RIGHT       3'h0
`define SJST_SHR1        3'h1
`define SJST_SHR2        3'h2
`define SJST_SHR3        3'h3

// timing: clock rate, converter power-up, sample rate limits
`define CLK_KHZ          125000
`define PWRUP_TIME_NS    1000
`define PWRUP_CYCLES     ((`PWRUP_TIME_NS * 125 + 999) / 1000)
`define RATE10_KSPS      300
`define RATE12_KSPS      75
`define RATE10_CYCLES    ((`CLK_KHZ + `RATE10_KSPS - 1) / `RATE10_KSPS)
`define RATE12_CYCLES    ((`CLK_KHZ + `RATE12_KSPS - 1) / `RATE12_KSPS)

`endif

// file: rtl/sample_accumulator.v
// 16-bit running sum of converter samples
`timescale 1ns/1ps
`default_nettype none
module sample_accumulator
(
    input  wire        clk,
    input  wire        rst,
    input  wire        load,
    input  wire        add,
    input  wire [11:0] sample,
    output reg  [15:0] sum_q
);
    reg [15:0] sum_d; // next sum

    // first sample of a series replaces the old sum, later ones add
    always @*
    begin
        sum_d = sum_q;
        if (load)
            sum_d = {4'h0, sample};
        else if (add)
            sum_d = sum_q + {4'h0, sample};
    end

    // sum register; wraps at 16 bits, which 64 x 10-bit never reaches
    always @(posedge clk)
    begin
        if (rst)
            sum_q <= 16'h0000;
        else
            sum_q <= sum_d;
    end
endmodule
`default_nettype wire

// file: rtl/result_formatter.v
// justify or shift the accumulated sum into the 16-bit result pair
`include "adc_result_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module result_formatter
(
    input  wire [15:0] sum,
    input  wire [2:0]  sjst,
    input  wire        res12,
    output reg  [15:0] fmt
);
    // unused positions are filled with zero in every format
    always @*
    begin
        fmt = 16'h0000;
        case (sjst)
            `SJST_RIGHT: fmt = sum;
            `SJST_SHR1:  fmt = {1'b0, sum[15:1]};
            `SJST_SHR2:  fmt = {2'b00, sum[15:2]};
            `SJST_SHR3:  fmt = {3'b000, sum[15:3]};
            default:
            begin
                // left justified single code: top bits of the pair
                if (res12)
                    fmt = {sum[11:0], 4'h0};
                else
                    fmt = {sum[9:0], 6'h00};
            end
        endcase
    end
endmodule
`default_nettype wire

// file: testbench/adc_result_asserts.sv
// port assertions for the converter result path
`timescale 1ns/1ps
`default_nettype none
module adc_result_checker
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        extStart,
    input wire logic        sampleValid,
    input wire logic [11:0] sampleCode,
    input wire logic        convStart_q,
    input wire logic        powerUp_q,
    input wire logic        res12Mode_q,
    input wire logic        irq_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    logic [11:0] gapCnt_q;  // cycles since the last start pulse, saturating

    // saturate so the first pulse after reset is never flagged
    always @(posedge clk)
    begin
        if (rst)
            gapCnt_q <= 12'hfff;
        else if (convStart_q)
            gapCnt_q <= 12'h001;
        else if (gapCnt_q != 12'hfff)
            gapCnt_q <= gapCnt_q + 12'h001;
    end

    sequence setupPhase;
        psel && !penable;
    endsequence
    sequence accessPhase;
        psel && penable;
    endsequence

    chk_one_wait: assert property (setupPhase ##1 accessPhase |-> !pready ##1 pready)
        else $error("pready not after exactly one wait state");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_ready: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response malformed");
    chk_data_quiet: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer cycle");
    chk_start_pulse: assert property (convStart_q |=> !convStart_q)
        else $error("start pulse too long");
    chk_start_gap: assert property (convStart_q |-> gapCnt_q >= 12'd417)
        else $error("conversions faster than allowed rate");
    chk_irq_cause: assert property ($rose(irq_q) |-> $past(sampleValid) || $past(sampleValid, 2)
        || $past(sampleValid, 3) || $past(extStart, 2) || $past(extStart, 3) || $past(pready)
        || $past(pready, 2) || $past(pready, 3))
        else $error("interrupt rose without cause");
    chk_irq_clear: assert property ($fell(irq_q) |-> $past(pready) || $past(pready, 2) || $past(pready, 3))
        else $error("interrupt fell without a register write");
endmodule
bind adc_result_accumulator_formatter adc_result_checker i_chk
(
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .extStart(extStart),
    .sampleValid(sampleValid), .sampleCode(sampleCode), .convStart_q(convStart_q),
    .powerUp_q(powerUp_q), .res12Mode_q(res12Mode_q), .irq_q(irq_q)
);
`default_nettype wire

// file: testbench/conv_core_model.sv
// behavioural converter core: one sample per start pulse
`timescale 1ns/1ps
`default_nettype none
module conv_core_model
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        convStart,
    input  wire logic        slow,
    input  wire logic        fixedEn,
    input  wire logic [11:0] fixedCode,
    output logic             sampleValid,
    output logic [11:0]      sampleCode
);
    int          waitCnt;  // cycles left in the running conversion
    logic [11:0] code;     // code of the next sample

    // the code bus toggles outside the valid cycle so stale data never looks right
    always @(posedge clk)
    begin
        code = fixedEn ? fixedCode : 12'($urandom);
        sampleValid <= 1'b0;
        sampleCode  <= ~sampleCode;
        if (rst)
        begin
            waitCnt    <= 0;
            sampleCode <= 12'h000;
        end
        else if (convStart)
            waitCnt <= slow ? 30 + $urandom_range(90) : 2;
        else if (waitCnt != 0)
        begin
            waitCnt <= waitCnt - 1;
            if (waitCnt == 1)
            begin
                sampleValid <= 1'b1;
                sampleCode  <= code;
            end
        end
    end
endmodule
`default_nettype wire

// file: testbench/adc_result_accumulator_formatter_bench.sv
// self-checking bench for the converter result path
`timescale 1ns/1ps
`default_nettype none
`include "adc_result_consts.vh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end
module adc_result_accumulator_formatter_bench;
    logic        clk, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic        extStart = 1'b0, slow = 1'b0, fixedEn = 1'b0, sampleValid, convStart_q;
    logic        powerUp_q, res12Mode_q, irq_q, err, pwrOld = 1'b0, res12 = 1'b0, maskOn;
    logic [7:0]  paddr = 8'h00;
    logic [11:0] fixedCode = 12'h000, sampleCode;
    logic [31:0] pwdata = 32'h0, prdata, rdData, ctrlBits = 32'h0;
    logic [15:0] sumAcc = 16'h0;  // running sum of every sample seen
    logic [9:0]  codes [4] = '{10'h3ff, 10'h200, 10'h100, 10'h000};
    logic [2:0]  sels [6] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7};
    int          cyc = 0, convCount = 0, lastStart = 0, lastGap = 0, pwrRise = 0;
    int          num_errors = 0, total_checks = 0;

    adc_result_accumulator_formatter i_dut
    (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .extStart(extStart),
        .sampleValid(sampleValid), .sampleCode(sampleCode), .convStart_q(convStart_q),
        .powerUp_q(powerUp_q), .res12Mode_q(res12Mode_q), .irq_q(irq_q)
    );
    conv_core_model i_core
    (
        .clk(clk), .rst(rst), .convStart(convStart_q), .slow(slow), .fixedEn(fixedEn),
        .fixedCode(fixedCode), .sampleValid(sampleValid), .sampleCode(sampleCode)
    );

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // observe the core link: sums, start counts and timing
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (sampleValid)
            sumAcc <= sumAcc + (res12 ? {4'h0, sampleCode} : {6'h00, sampleCode[9:0]});
        if (convStart_q)
        begin
            convCount <= convCount + 1;
            lastGap   <= cyc - lastStart;
            lastStart <= cyc;
        end
        if (powerUp_q && !pwrOld)
            pwrRise <= cyc;
        pwrOld <= powerUp_q;
    end

    function automatic logic [15:0] fmtExp(input logic [15:0] s, input logic [2:0] j);
        fmtExp = j[2] ? (s << 6) : (s >> j[1:0]);
    endfunction

    // one apb transfer; waits for pready, never assumes a latency
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 16)
        begin
            @(posedge clk);
            n++;
        end
        if (n == 16) `CHK(pready, 1'b1)
        rdData = prdata;
        err    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rdData, e)
    endtask

    task automatic waitSample;
        int n;
        n = 0;
        @(posedge clk);
        while (sampleValid !== 1'b1 && n < 2000)
        begin
            @(posedge clk);
            n++;
        end
        if (n == 2000) `CHK(sampleValid, 1'b1)
    endtask

    // start by pin pulse or by control write, off the busy-drop edge
    task automatic kick(input bit ext);
        repeat (2) @(posedge clk);
        if (ext)
        begin
            extStart <= 1'b1;
            @(posedge clk);
            extStart <= 1'b0;
        end
        else
            apb(1'b1, `OFS_CTRL, ctrlBits | 32'h2);
    endtask

    task automatic runSeries(input bit burst, input bit [2:0] sel, input bit [2:0] sj, input bit ext);
        int          n, k, c0, m;
        logic [15:0] base, prev, e;
        bit          drop;
        n    = (sel == 0 || sel > 5) ? 1 : 2 << sel;
        drop = 0;
        m    = 0;
        ctrlBits[0] = burst;
        apb(1'b1, `OFS_CTRL, ctrlBits);
        apb(1'b1, `OFS_ACC_CFG, {26'h0, sj, sel});
        apb(1'b0, `OFS_RESULT, 32'h0);
        prev = rdData[15:0];
        base = sumAcc;
        c0   = convCount;
        for (k = 0; k < n; k++)
        begin
            if (k == 0 || !burst)
                kick(ext);
            waitSample();
            if (k == 0 && burst)
                `CHK((lastStart - pwrRise) >= 125, 1'b1)
            if (k == 0 && n > 1)
            begin
                rdChk(`OFS_RESULT, {16'h0, prev});
                apb(1'b0, `OFS_STATUS, 32'h0);
                `CHK(rdData[1], 1'b0)
                if (burst)
                begin
                    `CHK(powerUp_q, 1'b1)
                    extStart <= 1'b1;
                    @(posedge clk);
                    extStart <= 1'b0;
                    drop = 1;
                end
                else
                begin
                    repeat (450) @(posedge clk);
                    `CHK(convCount - c0, 1)
                end
            end
        end
        do
        begin
            apb(1'b0, `OFS_STATUS, 32'h0);
            m++;
        end
        while (rdData[1] !== 1'b1 && m < 200);
        `CHK(rdData[1:0], 2'b10)
        e = fmtExp(sumAcc - base, sj);
        rdChk(`OFS_RESULT, {16'h0, e});
        rdChk(`OFS_RESULT_HIGH, {24'h0, e[15:8]});
        rdChk(`OFS_RESULT_LOW, {24'h0, e[7:0]});
        `CHK(convCount - c0, n)
        if (burst)
            `CHK(powerUp_q, 1'b0)
        if (n > 1)
            `CHK(lastGap >= (res12 ? 1667 : 417), 1'b1)
        rdChk(`OFS_INT_STATUS, {30'h0, drop, 1'b1});
        `CHK(irq_q, maskOn)
        apb(1'b1, `OFS_INT_STATUS, 32'h3);
        apb(1'b1, `OFS_STATUS, 32'h2);
        `CHK(irq_q, 1'b0)
        rdChk(`OFS_INT_STATUS, 32'h0);
    endtask

    task automatic wrap_up;
        if (num_errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // cut a hang short well beyond the expected run length
    initial
    begin
        repeat (90000) @(posedge clk);
        num_errors++;
        wrap_up();
    end

    initial
    begin
        int i;
        void'($urandom(61));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (i = 0; i < 8; i++)
            rdChk(8'(i * 4), 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        `CHK({err, rdData}, 33'h100000000)
        maskOn = 1'b1;
        apb(1'b1, `OFS_INT_MASK, 32'h3);
        // single results: table codes with junk upper bits, then random codes
        for (i = 0; i < 10; i++)
        begin
            fixedEn   <= (i < 8);
            fixedCode <= {2'b11, codes[(i / 2) % 4]};
            runSeries(1'b0, 3'h0, {i[0], 2'b00}, i[1]);
        end
        fixedEn <= 1'b0;
        for (i = 0; i < 6; i++)
        begin
            slow <= sels[i][0];
            runSeries(1'b1, sels[i], 3'($urandom_range(3)), i[0]);
        end
        runSeries(1'b0, 3'h1, 3'h1, 1'b1);
        res12 = 1'b1;
        ctrlBits[2] = 1'b1;
        apb(1'b1, `OFS_CTRL, ctrlBits);
        @(posedge clk); // the mode bit is latched one edge after the write lands
        `CHK(res12Mode_q, 1'b1)
        runSeries(1'b0, 3'h1, 3'h0, 1'b1);
        res12 = 1'b0;
        ctrlBits[2] = 1'b0;
        maskOn = 1'b0;
        apb(1'b1, `OFS_INT_MASK, 32'h0);
        runSeries(1'b0, 3'h0, 3'h0, 1'b0);
        wrap_up();
    end
endmodule
`default_nettype wire
